// file: hib_cfg_pkg.sv
/*
 * constants for the readout map and hibernate control block.
 * assumes one register port delivered by a serial engine on its own clock.
 */
`default_nettype none
package hib_cfg_pkg;
    // register addresses
    localparam logic [6:0] POL_ADDR = 7'h18;
    localparam logic [6:0] CFG_ADDR = 7'h19;
    localparam logic [6:0] X_LO_ADDR = 7'h04;
    localparam logic [6:0] Y_LO_ADDR = 7'h06;
    localparam logic [6:0] Z_LO_ADDR = 7'h08;
    localparam logic [6:0] MAG_LO_ADDR = 7'h0A;
    localparam logic [6:0] PTR_RST = 7'h00;
    // field positions of the config register
    localparam int MAG_EN_BIT = 4;
    localparam int X_SKIP_BIT = 3;
    localparam int Y_SKIP_BIT = 2;
    localparam int Z_SKIP_BIT = 1;
    localparam int HIB_BIT = 0;
    // values after reset, and the config write mask
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_MASK = 8'h1F;
    localparam logic POL_RST = 1'b1;
    // cycles a strap is given before it is caught
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    // most skipped bytes in a row
    localparam int SKIP_MAX = 8;
    typedef enum logic {PWR_RUN, PWR_HIB} pwr_t;
endpackage : hib_cfg_pkg
`default_nettype wire

// file: readout_map_hib.sv
/*
 * readout_and_hibernate_config register, burst address skipping,
 * magnitude estimate and hibernate entry and exit.
 * assumes a serial engine on link_clk that issues one register access
 * at a time; sensor data and odr_strobe come from logic on clk.
 */
// Functional notes
// - magnitude enable 0: no magnitude compute, magnitude bytes skipped in bursts
// - magnitude enable 1: magnitude computed each data cycle, bytes in bursts
// - magnitude feeds change detector input when its mode is 1
// - x skip bit 3 set drops x bytes from burst sequence
// - y skip bit 2 set drops y bytes from burst sequence
// - z skip bit 1 set drops z bytes from burst sequence
// - strap low, hibernate bit clear: device keeps running in configured modes
// - strap low, hibernate write 1: shut down, lose all registers
// - strap low: leave hibernate only on wake pin toggle
// - strap high: motion pin high puts device straight in active
// - strap high: motion pin low enters hibernate
// - irq polarity survives soft reset, lost on strap low hibernate, kept on motion pin hibernate
`default_nettype none
module readout_map_hib
    import hib_cfg_pkg::*;
(
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link clock and reset
    input wire logic link_clk,
    input wire logic link_rst_n,
    // sensor data, same clock
    input wire logic odr_strobe,
    input wire logic [11:0] x_data,
    input wire logic [11:0] y_data,
    input wire logic [11:0] z_data,
    input wire logic detector_mode,
    input wire logic soft_reset,
    // pins
    input wire logic wake_pin,
    input wire logic motion_detect_pin,
    input wire logic boot_mode_strap,
    // register access, link clock
    input wire logic cmd_valid,
    input wire logic cmd_first,
    input wire logic cmd_we,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    // status and results, core clock
    output logic [11:0] magnitude_out,
    output logic [11:0] change_det_input,
    output logic hibernating,
    output logic active_mode,
    output logic irq_polarity
);
    import hib_cfg_pkg::*;

    typedef struct packed {
        logic req_m, req_s, ack;
        logic wk_m, wk_s, wk_lvl;
        logic md_m, md_s;
        logic st_m, st_s, strap, strap_done;
        logic [1:0] strap_age;
        pwr_t st;
        logic hib, act, pol;
        logic [7:0] cfg, rdata;
        logic [6:0] ptr;
        logic [3:0] snap;
        logic [11:0] x, y, z, mag, cdet;
    } core_t;

    typedef struct packed {
        logic req, busy, ready;
        logic first, we;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic ack_m, ack_s;
        logic rv;
        logic [7:0] rd;
    } lnk_t;

    core_t q, c;
    lnk_t lq, lc;

    // absolute value of a two's complement sample
    function automatic logic [11:0] absv(input logic [11:0] v);
        return v[11] ? 12'(-v) : v;
    endfunction : absv

    // max + mid/2 + min/4, never above 3584 so no saturation
    function automatic logic [11:0] mag_est(
        input logic [11:0] a, input logic [11:0] b, input logic [11:0] d);
        logic [11:0] hi, lo, t, mx, md, mn;
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        mx = (hi > d) ? hi : d;
        t = (hi > d) ? d : hi;
        md = (lo > t) ? lo : t;
        mn = (lo > t) ? t : lo;
        return mx + (md >> 1) + (mn >> 2);
    endfunction : mag_est

    // sk = {x skip, y skip, z skip, magnitude off}
    function automatic logic skip_hit(input logic [6:0] n,
        input logic [3:0] sk);
        return (sk[3] && n[6:1] == X_LO_ADDR[6:1]) ||
               (sk[2] && n[6:1] == Y_LO_ADDR[6:1]) ||
               (sk[1] && n[6:1] == Z_LO_ADDR[6:1]) ||
               (sk[0] && n[6:1] == MAG_LO_ADDR[6:1]);
    endfunction : skip_hit

    // next burst address, stepping over skipped result bytes
    function automatic logic [6:0] next_addr(input logic [6:0] a,
        input logic [3:0] sk);
        logic [6:0] n;
        n = a + 7'h01;
        for (int i = 0; i < SKIP_MAX; i++)
        begin
            if (skip_hit(n, sk))
                n = n + 7'h01;
        end
        return n;
    endfunction : next_addr

    // core clock next state
    always_comb
    begin
        logic [6:0] a;
        logic [3:0] sk;
        logic [11:0] m;
        logic go_hib;
        c = q;
        a = lq.first ? lq.addr : q.ptr;
        sk = {q.cfg[X_SKIP_BIT], q.cfg[Y_SKIP_BIT], q.cfg[Z_SKIP_BIT],
              ~q.cfg[MAG_EN_BIT]};
        m = mag_est(absv(x_data), absv(y_data), absv(z_data));
        go_hib = 1'b0;
        // first flops feed only the second ones
        c.req_m = lq.req;
        c.req_s = q.req_m;
        c.wk_m = wake_pin;
        c.wk_s = q.wk_m;
        c.md_m = motion_detect_pin;
        c.md_s = q.md_m;
        c.st_m = boot_mode_strap;
        c.st_s = q.st_m;
        // strap caught once, after the synchroniser settles
        if (!q.strap_done)
        begin
            if (q.strap_age == STRAP_SETTLE)
            begin
                c.strap = q.st_s;
                c.strap_done = 1'b1;
            end
            else
                c.strap_age = q.strap_age + 2'h1;
        end
        // data cycle: results only while running
        if (q.st == PWR_RUN && odr_strobe)
        begin
            c.x = x_data;
            c.y = y_data;
            c.z = z_data;
            if (q.cfg[MAG_EN_BIT])
            begin
                c.mag = m;
                if (detector_mode)
                    c.cdet = m;
            end
        end
        if (soft_reset && q.st == PWR_RUN)
        begin
            c.cfg = CFG_RST; // polarity kept
            c.ptr = PTR_RST;
        end
        // one register access per request toggle
        if (q.req_s != q.ack)
        begin
            c.ack = q.req_s;
            c.rdata = 8'h00; // dead while hibernating
            if (q.st == PWR_RUN)
            begin
                // snapshot only at burst start
                if (!lq.first)
                    sk = q.snap;
                c.snap = sk;
                unique case (a)
                    X_LO_ADDR: c.rdata = q.x[7:0];
                    X_LO_ADDR + 7'h01: c.rdata = {4'h0, q.x[11:8]};
                    Y_LO_ADDR: c.rdata = q.y[7:0];
                    Y_LO_ADDR + 7'h01: c.rdata = {4'h0, q.y[11:8]};
                    Z_LO_ADDR: c.rdata = q.z[7:0];
                    Z_LO_ADDR + 7'h01: c.rdata = {4'h0, q.z[11:8]};
                    MAG_LO_ADDR: c.rdata = q.mag[7:0];
                    MAG_LO_ADDR + 7'h01: c.rdata = {4'h0, q.mag[11:8]};
                    POL_ADDR: c.rdata = {7'h00, q.pol};
                    CFG_ADDR: c.rdata = q.cfg;
                    default: c.rdata = 8'h00;
                endcase
                if (lq.we && a == CFG_ADDR)
                begin
                    c.cfg = lq.wdata & CFG_MASK;
                    go_hib = !q.strap && lq.wdata[HIB_BIT];
                end
                if (lq.we && a == POL_ADDR)
                    c.pol = lq.wdata[0];
                c.ptr = next_addr(a, sk);
            end
        end
        // strap high: pin level decides
        if (q.strap_done && q.strap)
        begin
            if (!q.md_s && q.st == PWR_RUN)
            begin
                c.st = PWR_HIB;
                c.x = 12'h000;
                c.y = 12'h000;
                c.z = 12'h000;
                c.mag = 12'h000;
                c.cdet = 12'h000;
            end
            else if (q.md_s)
                c.st = PWR_RUN;
        end
        else if (q.st == PWR_HIB && q.wk_s != q.wk_lvl)
        begin
            c.st = PWR_RUN; // either edge wakes
        end
        // strap low shutdown: like losing supply
        if (go_hib)
        begin
            c.st = PWR_HIB;
            c.wk_lvl = q.wk_s;
            c.cfg = CFG_RST;
            c.pol = POL_RST;
            c.ptr = PTR_RST;
            c.snap = 4'h0;
            c.x = 12'h000;
            c.y = 12'h000;
            c.z = 12'h000;
            c.mag = 12'h000;
            c.cdet = 12'h000;
        end
        c.hib = (c.st == PWR_HIB);
        c.act = (c.st == PWR_RUN) && c.strap_done && c.strap;
    end

    // core clock registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.st <= PWR_RUN;
            q.pol <= POL_RST;
            q.cfg <= CFG_RST;
            q.ptr <= PTR_RST;
        end
        else
            q <= c;
    end

    // link clock next state: toggle request, synchronised ack
    always_comb
    begin
        lc = lq;
        lc.ack_m = q.ack;
        lc.ack_s = lq.ack_m;
        lc.rv = 1'b0;
        if (lq.busy && lq.ack_s == lq.req)
        begin
            // core rdata is stable once its ack toggled
            lc.busy = 1'b0;
            lc.ready = 1'b1;
            lc.rv = 1'b1;
            lc.rd = q.rdata;
        end
        else if (cmd_valid && lq.ready)
        begin
            lc.req = ~lq.req;
            lc.busy = 1'b1;
            lc.ready = 1'b0;
            lc.first = cmd_first;
            lc.we = cmd_we;
            lc.addr = cmd_addr;
            lc.wdata = cmd_wdata;
        end
    end

    // link clock registers
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            lq <= '0;
            lq.ready <= 1'b1;
        end
        else
            lq <= lc;
    end

    assign cmd_ready = lq.ready;
    assign rsp_valid = lq.rv;
    assign rsp_data = lq.rd;
    assign magnitude_out = q.mag;
    assign change_det_input = q.cdet;
    assign hibernating = q.hib;
    assign active_mode = q.act;
    assign irq_polarity = q.pol;

    // checks on the core clock
    mag_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !q.cfg[MAG_EN_BIT] && !c.hib |=> $stable(q.mag)) // entry wipes
        else $error("magnitude changed while disabled");
    // estimate never falls below the largest axis, so a stale value shows
    mag_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
        odr_strobe && q.st == PWR_RUN && q.cfg[MAG_EN_BIT] && !c.hib
        |=> q.mag >= $past(absv(x_data)) && q.mag >= $past(absv(y_data))
        && q.mag >= $past(absv(z_data)))
        else $error("magnitude not computed");
    mag_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.snap[0] |-> q.ptr[6:1] != MAG_LO_ADDR[6:1])
        else $error("burst landed on magnitude bytes");
    x_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.snap[3] |-> q.ptr[6:1] != X_LO_ADDR[6:1])
        else $error("burst landed on x bytes");
    y_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.snap[2] |-> q.ptr[6:1] != Y_LO_ADDR[6:1])
        else $error("burst landed on y bytes");
    z_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.snap[1] |-> q.ptr[6:1] != Z_LO_ADDR[6:1])
        else $error("burst landed on z bytes");
    snap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.req_s == q.ack ##1 q.req_s == q.ack |-> $stable(q.snap))
        else $error("snapshot moved without access");
    hib_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.req_s != q.ack && q.st == PWR_RUN && !q.strap && lq.we &&
        lq.first && lq.addr == CFG_ADDR && lq.wdata[HIB_BIT]
        |=> hibernating && q.cfg == CFG_RST && irq_polarity == POL_RST)
        else $error("hibernate entry wrong");
    hib_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.hib && !q.strap && q.wk_s == q.wk_lvl |=> q.hib)
        else $error("left hibernate without toggle");
    md_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.strap_done && q.strap && !q.md_s ##1 !q.md_s |-> q.hib)
        else $error("motion low without hibernate");
    md_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        q.strap_done && q.strap && q.md_s |=> active_mode)
        else $error("motion high without active");
    pol_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset && q.req_s == q.ack |=> $stable(irq_polarity))
        else $error("polarity lost on soft reset");
    run_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        !q.hib && !q.strap && !q.cfg[HIB_BIT] && q.req_s == q.ack
        |=> !q.hib)
        else $error("hibernated without command");
    burst_c: cover property (@(posedge clk) disable iff (!rst_n)
        q.req_s != q.ack && !lq.first && q.snap != 4'h0);
    wake_c: cover property (@(posedge clk) disable iff (!rst_n)
        q.hib && !q.strap ##1 !q.hib);
    md_c: cover property (@(posedge clk) disable iff (!rst_n)
        q.strap && q.hib ##1 active_mode);
endmodule : readout_map_hib
`default_nettype wire

// file: host_link_model.sv
/*
 * host side model of the register port.
 * assumes link_clk from the bench; one access outstanding at a time.
 */
`default_nettype none
module host_link_model (
    // link clock
    input wire logic link_clk,
    // command
    output logic cmd_valid,
    output logic cmd_first,
    output logic cmd_we,
    output logic [6:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    // answer
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 100ps;
    parameter int BOOT_WAIT = 20;
    logic timed_out = 1'b0;
    // idle port at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_we = 1'b0;
        cmd_addr = 7'h00;
        cmd_wdata = 8'h00;
    end
    // one access: held until taken, then answer awaited
    task automatic acc(input logic first, input logic we,
        input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(negedge link_clk);
        cmd_valid = 1'b1;
        cmd_first = first;
        cmd_we = we;
        cmd_addr = a;
        cmd_wdata = wd;
        // ready only moves on posedge, so negedge shows what is sampled
        while (cmd_ready !== 1'b1 && n < 40)
        begin
            @(negedge link_clk);
            n++;
        end
        @(negedge link_clk);
        cmd_valid = 1'b0;
        cmd_addr = ~a; // released lines must not look stable
        cmd_wdata = ~wd;
        while (rsp_valid !== 1'b1 && n < 80)
        begin
            @(negedge link_clk);
            n++;
        end
        rd = rsp_data;
        if (n >= 40)
            timed_out = 1'b1;
    endtask : acc
    // boot delay before talking to the device again
    task automatic boot_wait();
        repeat (BOOT_WAIT) @(negedge link_clk);
    endtask : boot_wait
endmodule : host_link_model
`default_nettype wire

// file: readout_map_hib_test.sv
/*
 * self-checking bench for readout_map_hib.
 * assumes host_link_model drives the register port.
 */
`default_nettype none
module readout_map_hib_test;
    timeunit 1ns;
    timeprecision 100ps;
    import hib_cfg_pkg::*;
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
    logic odr_strobe = 1'b0, detector_mode = 1'b1, soft_reset = 1'b0;
    logic [11:0] x_data = 12'h040, y_data = 12'h020, z_data = 12'h010;
    logic wake_pin = 1'b0, motion_detect_pin = 1'b0, boot_mode_strap = 1'b0;
    logic cmd_valid, cmd_first, cmd_we, cmd_ready, rsp_valid;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_wdata, rsp_data, rd;
    logic [11:0] magnitude_out, change_det_input;
    logic hibernating, active_mode, irq_polarity;
    int miscompares = 0;
    int num_checks = 0;
    // clocks: link clock unrelated to core clock
    always #10 clk = ~clk;
    always #3 link_clk = ~link_clk;
    readout_map_hib DUT (.clk, .rst_n, .link_clk, .link_rst_n, .odr_strobe,
        .x_data, .y_data, .z_data, .detector_mode, .soft_reset, .wake_pin,
        .motion_detect_pin, .boot_mode_strap, .cmd_valid, .cmd_first,
        .cmd_we, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data,
        .magnitude_out, .change_det_input, .hibernating, .active_mode,
        .irq_polarity);
    host_link_model host (.link_clk, .cmd_valid, .cmd_first, .cmd_we,
        .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data);
    task automatic chk(input string nm, input logic [11:0] e,
        input logic [11:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input string nm, input logic f, input logic [6:0] a,
        input logic [7:0] e);
        host.acc(f, 1'b0, a, 8'h00, rd);
        chk(nm, {4'h0, e}, {4'h0, rd});
    endtask : rdc
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.acc(1'b1, 1'b1, a, d, rd);
    endtask : wr
    // bounded wait on the hibernate flag
    task automatic wait_hib(input logic v);
        int n;
        n = 0;
        while (hibernating !== v && n < 40)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_hib
    // strap is caught only after reset, so each strap needs its own
    task automatic do_reset(input logic strap);
        @(negedge clk);
        rst_n = 1'b0;
        link_rst_n = 1'b0;
        boot_mode_strap = strap;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge link_clk);
        link_rst_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : do_reset
    task automatic odr_pulse();
        @(negedge clk);
        odr_strobe = 1'b1;
        @(negedge clk);
        odr_strobe = 1'b0;
        repeat (3) @(negedge clk);
    endtask : odr_pulse
    task automatic tally_and_finish();
        if (host.timed_out)
            miscompares++;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // watchdog well past the expected run
    initial
    begin
        #400us;
        miscompares++;
        tally_and_finish();
    end
    // test sequence
    initial
    begin
        do_reset(1'b0);
        rdc("cfg reset", 1'b1, CFG_ADDR, CFG_RST);
        rdc("pol reset", 1'b1, POL_ADDR, 8'h01);
        $display("test reset done");
        wr(CFG_ADDR, 8'hF2);
        rdc("cfg rw", 1'b1, CFG_ADDR, 8'h12);
        chk("no hib", 12'h000, {11'h0, hibernating});
        odr_pulse();
        chk("magnitude", 12'h054, magnitude_out);
        chk("detector in", 12'h054, change_det_input);
        rdc("x lo", 1'b1, X_LO_ADDR, 8'h40);
        host.acc(1'b0, 1'b0, 7'h00, 8'h00, rd);
        rdc("y lo", 1'b0, 7'h00, 8'h20);
        host.acc(1'b0, 1'b0, 7'h00, 8'h00, rd);
        rdc("mag lo", 1'b0, 7'h00, 8'h54);
        // detector mode off: magnitude moves, detector input holds
        @(negedge clk);
        detector_mode = 1'b0;
        x_data = 12'hF80; // negative sample exercises the absolute value
        odr_pulse();
        chk("mag neg x", 12'h094, magnitude_out);
        chk("detector held", 12'h054, change_det_input);
        detector_mode = 1'b1;
        wr(CFG_ADDR, 8'h04);
        x_data = 12'h080;
        odr_pulse();
        chk("mag held", 12'h094, magnitude_out);
        rdc("x lo 2", 1'b1, X_LO_ADDR, 8'h80);
        host.acc(1'b0, 1'b0, 7'h00, 8'h00, rd);
        rdc("z after x", 1'b0, 7'h00, 8'h10);
        $display("test burst done");
        wr(POL_ADDR, 8'h00);
        @(negedge clk);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        rdc("pol soft", 1'b1, POL_ADDR, 8'h00);
        chk("pol pin", 12'h000, {11'h0, irq_polarity});
        rdc("cfg soft", 1'b1, CFG_ADDR, 8'h00);
        wr(CFG_ADDR, 8'h11);
        wait_hib(1'b1);
        chk("hib on", 12'h001, {11'h0, hibernating});
        rdc("hib read", 1'b1, CFG_ADDR, 8'h00);
        chk("hib stays", 12'h001, {11'h0, hibernating});
        @(negedge clk);
        wake_pin = 1'b1;
        wait_hib(1'b0);
        chk("woke", 12'h000, {11'h0, hibernating});
        host.boot_wait();
        rdc("cfg lost", 1'b1, CFG_ADDR, 8'h00);
        rdc("pol lost", 1'b1, POL_ADDR, 8'h01);
        chk("pol pin lost", 12'h001, {11'h0, irq_polarity});
        $display("test hibernate done");
        do_reset(1'b1);
        wait_hib(1'b1);
        chk("motion low", 12'h001, {11'h0, hibernating});
        motion_detect_pin = 1'b1;
        wait_hib(1'b0);
        host.boot_wait();
        repeat (2) @(negedge clk);
        chk("motion high", 12'h000, {11'h0, hibernating});
        chk("active", 12'h001, {11'h0, active_mode});
        motion_detect_pin = 1'b0;
        wait_hib(1'b1);
        chk("motion off", 12'h001, {11'h0, hibernating});
        $display("test motion pin done");
        tally_and_finish();
    end
endmodule : readout_map_hib_test
`default_nettype wire
